// >>> pkg/sceh_pkg.sv
// Package for the storage controller error handling block.
// Assumes a single 40 MHz clock domain and a plain register port.
package sceh_pkg;

    // Register offsets (byte addresses on the plain port)
    localparam logic [7:0] ADDR_CTRL     = 8'h00;
    localparam logic [7:0] ADDR_STATUS   = 8'h04;
    localparam logic [7:0] ADDR_IRQ_STAT = 8'h08;
    localparam logic [7:0] ADDR_IRQ_MASK = 8'h0C;
    localparam logic [7:0] ADDR_LAST_CPL = 8'h10;
    localparam logic [7:0] ADDR_QUEUE    = 8'h14;

    // Control register fields
    localparam int CTRL_STOP_DMA_RD = 0;
    localparam int CTRL_STOP_DMA_WR = 1;
    localparam int CTRL_WIDTH       = 2;

    // Status register fields
    localparam int STAT_FATAL = 0;
    localparam int STAT_BUSY  = 1;
    localparam int STAT_HALT  = 2;

    // Interrupt status bits
    localparam int IRQ_CPL     = 0;
    localparam int IRQ_ABORTQ  = 1;
    localparam int IRQ_MEDIA   = 2;
    localparam int IRQ_WIDTH   = 3;

    // Status codes (generic and media)
    localparam logic [7:0] SC_SUCCESS       = 8'h00;
    localparam logic [7:0] SC_DATA_XFER_ERR = 8'h04;
    localparam logic [7:0] SC_ABORT_SQ_DEL  = 8'h08;
    localparam logic [7:0] SC_INTERNAL_ERR  = 8'h06;
    localparam logic [7:0] SC_WRITE_FAULT   = 8'h80;
    localparam logic [7:0] SC_UNREC_READ    = 8'h81;
    localparam logic [7:0] SC_GUARD_ERR     = 8'h82;
    localparam logic [7:0] SC_APPTAG_ERR    = 8'h83;

    localparam logic [2:0] SCT_GENERIC = 3'h0;
    localparam logic [2:0] SCT_MEDIA   = 3'h2;

    // Error condition vector positions
    localparam int ERR_WR_FAULT  = 0;
    localparam int ERR_RD_UNREC  = 1;
    localparam int ERR_GUARD     = 2;
    localparam int ERR_APPTAG    = 3;
    localparam int ERR_MEM_ABORT = 4;
    localparam int ERR_DRAM      = 5;
    localparam int ERR_PWR_LOSS  = 6;
    localparam int ERR_WIDTH     = 7;

    localparam logic [31:0] RESET_WORD = 32'h0000_0000;

    // Command completion request from the command engine
    typedef struct packed {
        logic [15:0] cid;
        logic [7:0]  sqid;
        logic        is_write;
        logic        limited_retry;
        logic        exhausted;
        logic [15:0] nlb;
        logic [ERR_WIDTH-1:0] err;
    } sceh_cmd_t;

    // Completion entry status posted to the queue logic
    typedef struct packed {
        logic [15:0] cid;
        logic [7:0]  sqid;
        logic [2:0]  sct;
        logic [7:0]  sc;
        logic        dnr;
        logic        more;
    } sceh_cpl_t;

endpackage

// >>> verilog/sceh_prio.sv
// Status code selection for one failing command.
// Pure combinational; fed from flops of the same clock.
`timescale 1ns/1ps
module sceh_prio (
    // Error inputs
    input  wire logic [sceh_pkg::ERR_WIDTH-1:0] err,
    // Selected status
    output logic                                 any_err,
    output logic [2:0]                           sct,
    output logic [7:0]                           sc
);
    // Generic codes are numerically below media codes, so checking them
    // first returns the lowest value when several conditions coexist.
    always_comb begin
        any_err = |err;
        sct     = sceh_pkg::SCT_GENERIC;
        sc      = sceh_pkg::SC_SUCCESS;
        if (err[sceh_pkg::ERR_MEM_ABORT]) begin
            sc = sceh_pkg::SC_DATA_XFER_ERR; // RULE13
        end else if (err[sceh_pkg::ERR_DRAM] || err[sceh_pkg::ERR_PWR_LOSS]) begin
            sc = sceh_pkg::SC_INTERNAL_ERR; // RULE14
        end else if (err[sceh_pkg::ERR_WR_FAULT]) begin
            sct = sceh_pkg::SCT_MEDIA; // RULE5
            sc  = sceh_pkg::SC_WRITE_FAULT;
        end else if (err[sceh_pkg::ERR_RD_UNREC]) begin
            sct = sceh_pkg::SCT_MEDIA;
            sc  = sceh_pkg::SC_UNREC_READ;
        end else if (err[sceh_pkg::ERR_GUARD]) begin
            sct = sceh_pkg::SCT_MEDIA;
            sc  = sceh_pkg::SC_GUARD_ERR;
        end else if (err[sceh_pkg::ERR_APPTAG]) begin
            sct = sceh_pkg::SCT_MEDIA;
            sc  = sceh_pkg::SC_APPTAG_ERR;
        end
    end
endmodule

// >>> verilog/sceh_top.sv
// Error reporting and recovery for a queue based storage controller.
// Assumes one clock, commands and queue events arrive from same-clock logic,
// and the fault pin is asynchronous.
// Summary of operation
// RULE1: Deleting SQ aborts its commands, frees resources
// RULE2: Host deletes and recreates a broken queue
// RULE3: Host resets controller on admin errors
// RULE4: Keep running; flag retry hint per failure
// RULE5: Media failure completes with media status code
// RULE6: Read error may stop DMA to host
// RULE7: Host ignores buffers of read-error commands
// RULE8: Write error may stop or finish DMA
// RULE9: Small failed write keeps previous data
// RULE10: Large failed write may keep either data
// RULE11: Limited retry bit selects recovery effort
// RULE12: Memory errors halt command, need host
// RULE13: Bad host pointer gives data transfer error
// RULE14: Internal error status, lowest code wins
// RULE15: Host ignores data of internal error commands
// RULE16: Unpostable completions set the fatal flag
// RULE17: Fatal flag never raises an interrupt
// RULE18: Host polls fatal flag, then reinitialises
// RULE19: Fatal flag clears only on reset
//
// Decided for this implementation: the register addresses and strobed register access.
`timescale 1ns/1ps
module sceh_top #(
    parameter int NUM_SQ   = 8,
    parameter int AWUPF    = 16
) (
    // Clock and reset
    input  wire logic                  clock,
    input  wire logic                  resetn,
    // Register port
    input  wire logic [7:0]            reg_addr,
    input  wire logic [31:0]           reg_wdata,
    input  wire logic                  reg_wr,
    input  wire logic                  reg_rd,
    output logic [31:0]                reg_rdata,
    // Command completion requests
    input  wire logic                  cmd_valid,
    input  wire sceh_pkg::sceh_cmd_t   cmd,
    // Queue management
    input  wire logic                  sq_delete,
    input  wire logic                  cq_delete,
    input  wire logic [7:0]            del_qid,
    input  wire logic [NUM_SQ-1:0]     sq_outstanding,
    // Completion posting path
    input  wire logic                  cq_post_fail,
    output logic                       cpl_valid,
    output sceh_pkg::sceh_cpl_t        cpl,
    // Data path control
    output logic                       dma_stop,
    output logic                       commit_write,
    output logic                       cmd_halt,
    output logic [NUM_SQ-1:0]          sq_abort,
    output logic                       q_release,
    output logic                       retry_more,
    // Fault input and status
    input  wire logic                  fault_pin,
    output logic                       controller_fatal_flag,
    output logic                       irq
);
    localparam int IW = sceh_pkg::IRQ_WIDTH;

    default clocking dflt_cb @(posedge clock);
    endclocking
    default disable iff (!resetn);

    logic [sceh_pkg::CTRL_WIDTH-1:0] ctrl_ff;
    logic [IW-1:0]                   irq_stat_ff;
    logic [IW-1:0]                   irq_mask_ff;
    logic                            fatal_ff;
    logic                            halt_ff;
    logic                            fault_s1_ff;
    logic                            fault_s2_ff;
    logic                            cpl_valid_ff;
    sceh_pkg::sceh_cpl_t             cpl_ff;
    logic                            dma_stop_ff;
    logic                            commit_ff;
    logic                            more_ff;
    logic [NUM_SQ-1:0]               sq_abort_ff;
    logic                            q_release_ff;
    logic [31:0]                     rdata_ff;
    logic [IW-1:0]                   ev;
    logic                            any_err;
    logic [2:0]                      p_sct;
    logic [7:0]                      p_sc;
    logic                            is_read_err;
    logic                            small_write;
    logic                            mem_abort;
    logic                            do_cmd;

    function automatic logic hit(input logic [7:0] a, input logic [7:0] b);
        return a == b;
    endfunction

    sceh_prio u_prio (
        .err     (cmd.err),
        .any_err (any_err),
        .sct     (p_sct),
        .sc      (p_sc)
    );

    // Commands are dropped once halted or fatal; only a reset resumes
    assign do_cmd      = cmd_valid && !halt_ff && !fatal_ff;
    assign mem_abort   = cmd.err[sceh_pkg::ERR_MEM_ABORT];
    assign is_read_err = cmd.err[sceh_pkg::ERR_RD_UNREC] ||
                         (!cmd.is_write && cmd.err[sceh_pkg::ERR_GUARD]);
    // nlb is zero based, so a value below the unit size fits in one unit
    assign small_write = {16'h0000, cmd.nlb} < 32'(AWUPF);

    // Fault pin synchroniser
    // Only the second stage is read, so no logic sees a metastable value
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            fault_s1_ff <= 1'b0;
            fault_s2_ff <= 1'b0;
        end else begin
            fault_s1_ff <= fault_pin;
            fault_s2_ff <= fault_s1_ff;
        end
    end

    // Sticky fatal flag, only reset clears it
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            fatal_ff <= 1'b0;
        end else if (cq_post_fail || fault_s2_ff) begin
            fatal_ff <= 1'b1; // RULE16 RULE19
        end
    end

    // Host memory errors halt command processing until reset
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            halt_ff <= 1'b0;
        end else if (do_cmd && mem_abort) begin
            halt_ff <= 1'b1; // RULE12
        end
    end

    // Completion builder
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            cpl_valid_ff <= 1'b0;
            cpl_ff       <= '0;
            dma_stop_ff  <= 1'b0;
            commit_ff    <= 1'b0;
            more_ff      <= 1'b0;
        end else begin
            cpl_valid_ff <= do_cmd;
            dma_stop_ff  <= 1'b0;
            commit_ff    <= 1'b0;
            if (do_cmd) begin
                cpl_ff.cid  <= cmd.cid;
                cpl_ff.sqid <= cmd.sqid;
                cpl_ff.sct  <= p_sct; // RULE5 RULE13 RULE14
                cpl_ff.sc   <= p_sc;
                // Retry hint: reissue may succeed unless recovery is exhausted
                // or the fault is a host memory abort
                cpl_ff.dnr  <= any_err && (cmd.exhausted || mem_abort); // RULE4
                cpl_ff.more <= any_err;
                // Limited retry or exhausted recovery skips further recovery; full recovery otherwise
                more_ff     <= any_err && !cmd.limited_retry && !cmd.exhausted; // RULE11
                if (is_read_err) begin
                    dma_stop_ff <= ctrl_ff[sceh_pkg::CTRL_STOP_DMA_RD]; // RULE6
                end else if (cmd.is_write && any_err) begin
                    dma_stop_ff <= ctrl_ff[sceh_pkg::CTRL_STOP_DMA_WR]; // RULE8
                end
                // A bad host pointer leaves nothing valid to move
                if (mem_abort) begin
                    dma_stop_ff <= 1'b1; // RULE13
                end
                // Failed writes within the atomic unit never commit; larger
                // ones commit partially, so either data may be read back
                commit_ff <= cmd.is_write && (!any_err || !small_write); // RULE9 RULE10
            end
        end
    end

    // Queue deletion: abort outstanding commands and free resources
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            sq_abort_ff  <= '0;
            q_release_ff <= 1'b0;
        end else begin
            q_release_ff <= sq_delete || cq_delete; // RULE1
            for (int i = 0; i < NUM_SQ; i++) begin
                sq_abort_ff[i] <= sq_delete && hit(del_qid, 8'(i)) &&
                                  sq_outstanding[i]; // RULE1
            end
        end
    end

    // Events: completion, queue abort, media error. Fatal is not an event.
    assign ev[sceh_pkg::IRQ_CPL]    = cpl_valid_ff;
    assign ev[sceh_pkg::IRQ_ABORTQ] = |sq_abort_ff;
    assign ev[sceh_pkg::IRQ_MEDIA]  = cpl_valid_ff && (cpl_ff.sct == sceh_pkg::SCT_MEDIA);

    // Register writes
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            ctrl_ff     <= '0;
            irq_mask_ff <= '0;
        end else if (reg_wr) begin
            if (hit(reg_addr, sceh_pkg::ADDR_CTRL)) begin
                ctrl_ff <= reg_wdata[sceh_pkg::CTRL_WIDTH-1:0];
            end
            if (hit(reg_addr, sceh_pkg::ADDR_IRQ_MASK)) begin
                irq_mask_ff <= reg_wdata[IW-1:0];
            end
        end
    end

    // Sticky status; a new event wins over a write-one clear
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            irq_stat_ff <= '0;
        end else begin
            for (int i = 0; i < IW; i++) begin
                if (ev[i]) begin
                    irq_stat_ff[i] <= 1'b1;
                end else if (reg_wr && hit(reg_addr, sceh_pkg::ADDR_IRQ_STAT) &&
                             reg_wdata[i]) begin
                    irq_stat_ff[i] <= 1'b0;
                end
            end
        end
    end

    // Register reads, data one cycle later
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            rdata_ff <= sceh_pkg::RESET_WORD;
        end else if (reg_rd) begin
            rdata_ff <= sceh_pkg::RESET_WORD;
            case (reg_addr)
                sceh_pkg::ADDR_CTRL: begin
                    rdata_ff[sceh_pkg::CTRL_WIDTH-1:0] <= ctrl_ff;
                end
                sceh_pkg::ADDR_STATUS: begin
                    rdata_ff[sceh_pkg::STAT_FATAL] <= fatal_ff; // RULE17
                    rdata_ff[sceh_pkg::STAT_BUSY]  <= cpl_valid_ff;
                    rdata_ff[sceh_pkg::STAT_HALT]  <= halt_ff;
                end
                sceh_pkg::ADDR_IRQ_STAT: begin
                    rdata_ff[IW-1:0] <= irq_stat_ff;
                end
                sceh_pkg::ADDR_IRQ_MASK: begin
                    rdata_ff[IW-1:0] <= irq_mask_ff;
                end
                sceh_pkg::ADDR_LAST_CPL: begin
                    rdata_ff[31:0] <= {cpl_ff.cid, cpl_ff.sc, 2'b00, cpl_ff.dnr,
                                       cpl_ff.more, 1'b0, cpl_ff.sct};
                end
                sceh_pkg::ADDR_QUEUE: begin
                    rdata_ff[NUM_SQ-1:0] <= sq_outstanding;
                end
                default: begin
                    rdata_ff <= sceh_pkg::RESET_WORD;
                end
            endcase
        end else begin
            rdata_ff <= sceh_pkg::RESET_WORD;
        end
    end

    assign reg_rdata             = rdata_ff;
    assign cpl_valid             = cpl_valid_ff;
    assign cpl                   = cpl_ff;
    assign dma_stop              = dma_stop_ff;
    assign commit_write          = commit_ff;
    assign cmd_halt              = halt_ff;
    assign sq_abort              = sq_abort_ff;
    assign q_release             = q_release_ff;
    assign retry_more            = more_ff;
    assign controller_fatal_flag = fatal_ff;
    // The fatal flag is deliberately absent from the interrupt path
    assign irq                   = |(irq_stat_ff & irq_mask_ff); // RULE17

    // Assertions
    // Memory abort: error completion, then nothing while halted
    sequence abort_cpl_s;
        cpl_valid && dma_stop && cpl.sc == sceh_pkg::SC_DATA_XFER_ERR;
    endsequence
    sequence halted_s;
        !cpl_valid ##1 halt_ff;
    endsequence

    // Fatal flag and interrupt
    fatal_sticky_a: assert property ( // RULE19
        fatal_ff |=> fatal_ff)
        else $error("fatal flag dropped");
    fatal_set_a: assert property ( // RULE16
        cq_post_fail |=> fatal_ff)
        else $error("fatal flag not set");
    fatal_refuse_a: assert property ( // RULE16
        fatal_ff |=> !cpl_valid)
        else $error("completion while fatal");
    fatal_noirq_a: assert property ( // RULE17
        $rose(irq) |-> $past(|ev) || $past(reg_wr))
        else $error("irq without event");

    // Queue deletion
    sq_abort_a: assert property ( // RULE1
        sq_delete && del_qid == 8'h00 && sq_outstanding[0] |=> sq_abort[0])
        else $error("outstanding command not aborted");
    q_release_a: assert property ( // RULE1
        $rose(q_release) |-> $past(sq_delete) || $past(cq_delete))
        else $error("bad release");
    abort_release_a: assert property ( // RULE1
        |sq_abort |-> q_release)
        else $error("abort without release");

    // Completions
    xfer_err_a: assert property ( // RULE13
        do_cmd && mem_abort |=> abort_cpl_s)
        else $error("no data transfer error");
    halt_hold_a: assert property ( // RULE12
        halt_ff |=> halted_s)
        else $error("processing after memory error");
    atomic_wr_a: assert property ( // RULE9
        do_cmd && cmd.is_write && any_err && small_write |=> !commit_write)
        else $error("small failed write committed");
    big_wr_a: assert property ( // RULE10
        do_cmd && cmd.is_write && !small_write |=> commit_write)
        else $error("large write not committed");
    internal_a: assert property ( // RULE14
        do_cmd && !mem_abort && cmd.err[sceh_pkg::ERR_DRAM] |=>
        cpl.sc == sceh_pkg::SC_INTERNAL_ERR)
        else $error("internal error code wrong");
    media_a: assert property ( // RULE5
        do_cmd && cmd.err == 7'h02 |=> cpl.sct == sceh_pkg::SCT_MEDIA)
        else $error("media status missing");
    no_err_a: assert property ( // RULE4
        do_cmd && !any_err |=> !cpl.dnr && !cpl.more)
        else $error("hint on clean completion");
    retry_hint_a: assert property ( // RULE11
        do_cmd && cmd.limited_retry |=> !retry_more)
        else $error("recovery despite limited retry");
    rd_dma_a: assert property ( // RULE6
        do_cmd && is_read_err && ctrl_ff[sceh_pkg::CTRL_STOP_DMA_RD] |=> dma_stop)
        else $error("read error dma not stopped");
    wr_dma_a: assert property ( // RULE8
        do_cmd && cmd.is_write && any_err && !is_read_err &&
        ctrl_ff[sceh_pkg::CTRL_STOP_DMA_WR] |=> dma_stop)
        else $error("write error dma not stopped");
endmodule

// >>> test/sceh_host_model.sv
// Host software model: drives the register port of the error handling block.
// Assumes read data stand only in the cycle after the read strobe.
`timescale 1ns/1ps
module sceh_host_model (
    // Clock
    input  wire logic        clock,
    // Register port
    output logic [7:0]       reg_addr,
    output logic [31:0]      reg_wdata,
    output logic             reg_wr,
    output logic             reg_rd,
    input  wire logic [31:0] reg_rdata
);
    initial begin
        reg_addr  = 8'h00;
        reg_wdata = 32'h0000_0000;
        reg_wr    = 1'b0;
        reg_rd    = 1'b0;
    end
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clock);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge clock);
        reg_wr    <= 1'b0;
        // Released data must not look like the last word
        reg_wdata <= ~d;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge clock);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge clock);
        reg_rd   <= 1'b0;
        #1 d = reg_rdata;
    endtask
    // After errors the host looks at the fatal flag before deciding to reset
    task automatic poll_fatal(output logic f);
        logic [31:0] s;
        rd(sceh_pkg::ADDR_STATUS, s);
        f = s[sceh_pkg::STAT_FATAL];
    endtask
endmodule

// >>> test/sceh_top_tb_top.sv
// Self-checking bench for the error handling block, random and directed.
// Assumes the host model drives the register port; bench drives the rest.
`timescale 1ns/1ps
module sceh_top_tb_top;
    localparam int NSQ = 8;
    localparam int AWU = 16;
    logic                clock = 1'b0;
    logic                resetn = 1'b0;
    logic [7:0]          reg_addr;
    logic [31:0]         reg_wdata;
    logic                reg_wr;
    logic                reg_rd;
    logic [31:0]         reg_rdata;
    logic                cmd_valid = 1'b0;
    sceh_pkg::sceh_cmd_t cmd = '0;
    logic                sq_delete = 1'b0;
    logic                cq_delete = 1'b0;
    logic [7:0]          del_qid = 8'h00;
    logic [NSQ-1:0]      sq_outstanding = '0;
    logic                cq_post_fail = 1'b0;
    logic                cpl_valid;
    sceh_pkg::sceh_cpl_t cpl;
    logic                dma_stop;
    logic                commit_write;
    logic                cmd_halt;
    logic [NSQ-1:0]      sq_abort;
    logic                q_release;
    logic                retry_more;
    logic                fault_pin = 1'b0;
    logic                controller_fatal_flag;
    logic                irq;
    int                  errors = 0;
    int                  n_checks = 0;
    int                  seed = 84;
    logic [31:0]         rv;
    logic                f;
    logic                ds, cw;
    logic [6:0]          tbl [7] = '{7'h01, 7'h02, 7'h04, 7'h08, 7'h20, 7'h40, 7'h6E};

    always #12.5 clock = ~clock;

    sceh_top #(.NUM_SQ(NSQ), .AWUPF(AWU)) i_dut (.clock(clock), .resetn(resetn),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .cmd_valid(cmd_valid), .cmd(cmd), .sq_delete(sq_delete),
        .cq_delete(cq_delete), .del_qid(del_qid), .sq_outstanding(sq_outstanding),
        .cq_post_fail(cq_post_fail), .cpl_valid(cpl_valid), .cpl(cpl), .dma_stop(dma_stop),
        .commit_write(commit_write), .cmd_halt(cmd_halt), .sq_abort(sq_abort),
        .q_release(q_release), .retry_more(retry_more), .fault_pin(fault_pin),
        .controller_fatal_flag(controller_fatal_flag), .irq(irq));
    sceh_host_model i_host (.clock(clock), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));

    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        n_checks++;
        if (seen !== exp) begin
            errors++;
            $display("unexpected at %0t: %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask
    task automatic report_and_stop();
        $display("errors %0d, checks %0d", errors, n_checks);
        if (errors == 0 && n_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    // Lowest code wins among the conditions present
    function automatic logic [7:0] exp_sc(input logic [6:0] e);
        if (e[4]) return sceh_pkg::SC_DATA_XFER_ERR;
        if (e[5] | e[6]) return sceh_pkg::SC_INTERNAL_ERR;
        if (e[0]) return sceh_pkg::SC_WRITE_FAULT;
        if (e[1]) return sceh_pkg::SC_UNREC_READ;
        if (e[2]) return sceh_pkg::SC_GUARD_ERR;
        if (e[3]) return sceh_pkg::SC_APPTAG_ERR;
        return sceh_pkg::SC_SUCCESS;
    endfunction
    function automatic sceh_pkg::sceh_cmd_t mk(input logic [15:0] id, input logic w,
            input logic ex, input logic [15:0] n, input logic [6:0] e);
        sceh_pkg::sceh_cmd_t c;
        c = '{cid: id, sqid: id[7:0], is_write: w, limited_retry: id[0], exhausted: ex,
              nlb: n, err: e};
        return c;
    endfunction
    task automatic do_reset(input int n);
        resetn <= 1'b0;
        repeat (n) @(posedge clock);
        resetn <= 1'b1;
    endtask
    task automatic send(input sceh_pkg::sceh_cmd_t c, input logic taken);
        logic [7:0] sc;
        logic       dnr;
        logic [2:0] sct;
        sc  = exp_sc(c.err);
        sct = sc[7] ? sceh_pkg::SCT_MEDIA : sceh_pkg::SCT_GENERIC;
        dnr = (|c.err) & (c.exhausted | c.err[4]);
        @(posedge clock);
        cmd_valid <= 1'b1;
        cmd       <= c;
        @(posedge clock);
        cmd_valid <= 1'b0;
        #1;
        ds = dma_stop;
        cw = commit_write;
        check(cpl_valid, taken, "cpl_valid");
        if (taken) begin
            check(cpl.cid, c.cid, "cid");
            check(cpl.sqid, c.sqid, "sqid");
            check(cpl.sc, sc, "sc");
            check(cpl.sct, sct, "sct");
            check(cpl.dnr, dnr, "dnr");
            check(cpl.more, |c.err, "more");
            check(retry_more, |c.err & ~c.limited_retry & ~c.exhausted, "retry");
            i_host.rd(sceh_pkg::ADDR_LAST_CPL, rv);
            check(rv, {c.cid, sc, 2'b00, dnr, |c.err, 1'b0, sct}, "last_cpl");
        end
    endtask
    task automatic qdel(input logic s, input logic [7:0] q, input logic [NSQ-1:0] o);
        @(posedge clock);
        sq_delete      <= s;
        cq_delete      <= ~s;
        del_qid        <= q;
        sq_outstanding <= o;
        @(posedge clock);
        sq_delete <= 1'b0;
        cq_delete <= 1'b0;
        #1;
        check(sq_abort, s ? o & (NSQ'(1) << q[2:0]) : '0, "sq_abort");
        check(q_release, 1'b1, "q_release");
    endtask

    initial begin
        #(25 * 40000);
        errors++;
        report_and_stop();
    end

    initial begin
        do_reset(20);
        #1;
        check(controller_fatal_flag, 1'b0, "fatal at reset");
        i_host.wr(sceh_pkg::ADDR_STATUS, 32'hFFFF_FFFF);
        i_host.rd(sceh_pkg::ADDR_STATUS, rv);
        check(rv, 32'h0000_0000, "status read only");
        i_host.rd(8'h20, rv);
        check(rv, 32'h0000_0000, "unmapped");
        foreach (tbl[i]) send(mk(16'(i), i[0], i[1], 16'h0003, tbl[i]), 1'b1);
        repeat (40) begin
            rv = $random(seed);
            send(mk(rv[31:16], rv[7], rv[8], {12'h000, rv[12:9]}, rv[6:0] & 7'h6F), 1'b1);
        end
        // Read errors with each DMA stop choice, a write error with the write stop set
        i_host.wr(sceh_pkg::ADDR_CTRL, 32'h0000_0001);
        send(mk(16'h0101, 1'b0, 1'b0, 16'h0000, 7'h02), 1'b1);
        check(ds, 1'b1, "dma stop on read");
        i_host.wr(sceh_pkg::ADDR_CTRL, 32'h0000_0002);
        send(mk(16'h0102, 1'b0, 1'b0, 16'h0000, 7'h02), 1'b1);
        check(ds, 1'b0, "dma runs on read");
        send(mk(16'h0103, 1'b1, 1'b0, 16'(AWU - 1), 7'h04), 1'b1);
        check(ds, 1'b1, "dma stop on write");
        check(cw, 1'b0, "small failed write");
        send(mk(16'h0104, 1'b1, 1'b0, 16'(AWU + 4), 7'h00), 1'b1);
        check(cw, 1'b1, "good write");
        i_host.rd(sceh_pkg::ADDR_CTRL, rv);
        check(rv, 32'h0000_0002, "ctrl readback");
        // Interrupt: raised, masked, cleared
        i_host.rd(sceh_pkg::ADDR_IRQ_STAT, rv);
        check(rv[sceh_pkg::IRQ_CPL], 1'b1, "cpl event");
        check(irq, 1'b0, "irq masked");
        i_host.wr(sceh_pkg::ADDR_IRQ_MASK, 32'h0000_0007);
        #1 check(irq, 1'b1, "mask raises irq");
        i_host.wr(sceh_pkg::ADDR_IRQ_STAT, 32'h0000_0007);
        i_host.rd(sceh_pkg::ADDR_IRQ_STAT, rv);
        check(rv, 32'h0000_0000, "w1c");
        check(irq, 1'b0, "irq cleared");
        // Submission and completion queue deletion by the host
        qdel(1'b1, 8'h02, 8'h04);
        qdel(1'b1, 8'h03, 8'h04);
        qdel(1'b0, 8'h02, 8'h04);
        repeat (10) begin
            rv = $random(seed);
            qdel(1'b1, {5'h00, rv[2:0]}, rv[15:8]);
        end
        i_host.rd(sceh_pkg::ADDR_QUEUE, rv);
        check(rv, {24'h00_0000, sq_outstanding}, "queue reg");
        // Host memory abort halts the engine until reset
        send(mk(16'h0201, 1'b0, 1'b0, 16'h0000, 7'h10), 1'b1);
        check(cmd_halt, 1'b1, "halt");
        check(ds, 1'b1, "abort stops dma");
        send(mk(16'h0202, 1'b0, 1'b0, 16'h0000, 7'h00), 1'b0);
        do_reset(2);
        i_host.wr(sceh_pkg::ADDR_IRQ_STAT, 32'h0000_0007);
        i_host.wr(sceh_pkg::ADDR_IRQ_MASK, 32'h0000_0007);
        @(posedge clock);
        cq_post_fail <= 1'b1;
        @(posedge clock);
        cq_post_fail <= 1'b0;
        #1 check(controller_fatal_flag, 1'b1, "fatal set");
        repeat (30) @(posedge clock);
        check(controller_fatal_flag, 1'b1, "fatal sticky");
        check(irq, 1'b0, "no irq on fatal");
        i_host.poll_fatal(f);
        check(f, 1'b1, "status fatal");
        send(mk(16'h0301, 1'b0, 1'b0, 16'h0000, 7'h00), 1'b0);
        do_reset(2);
        #1 check(controller_fatal_flag, 1'b0, "fatal cleared");
        fault_pin <= 1'b1;
        repeat (5) @(posedge clock);
        #1 check(controller_fatal_flag, 1'b1, "fault pin");
        check(irq, 1'b0, "no irq on fault");
        fault_pin <= 1'b0;
        report_and_stop();
    end
endmodule
